// ---- logic/psw_ctl_pkg.sv ----
package psw_ctl_pkg;
  // ---------------------------------------------------------------
  // status word field positions
  // ---------------------------------------------------------------
  localparam int SYS_MASK_LO = 0;
  localparam int SYS_MASK_HI = 7;
  localparam int EXT_MASK_BIT = 7;
  localparam int ASCII_BIT = 12;
  localparam int MCHK_MASK_BIT = 13;
  localparam int WAIT_BIT = 14;
  localparam int PROB_BIT = 15;
  localparam int ICODE_LO = 16;
  localparam int ICODE_HI = 31;
  localparam int PMASK_LO = 36;
  localparam int PMASK_HI = 39;
  localparam int PSW_W = 64;
  localparam int ADDR_W = 12;
  localparam int NUM_CHAN = 7;
  localparam int NUM_PEXC = 15;
  // program exception positions: the four maskable ones, then privileged operation
  localparam int PEXC_FXOVF = 8;
  localparam int PEXC_DCOVF = 10;
  localparam int PEXC_EXPUF = 13;
  localparam int PEXC_SIGNF = 14;
  localparam int PEXC_PRIV = 2;
  // ---------------------------------------------------------------
  // low storage locations
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] EXT_OLD = 12'd24;
  localparam logic [ADDR_W-1:0] PGM_OLD = 12'd40;
  localparam logic [ADDR_W-1:0] MCH_OLD = 12'd48;
  localparam logic [ADDR_W-1:0] IO_OLD = 12'd56;
  localparam logic [ADDR_W-1:0] EXT_NEW = 12'd88;
  localparam logic [ADDR_W-1:0] PGM_NEW = 12'd104;
  localparam logic [ADDR_W-1:0] MCH_NEW = 12'd112;
  localparam logic [ADDR_W-1:0] IO_NEW = 12'd120;
  localparam logic [ADDR_W-1:0] LOG_BASE = 12'd128;
  // supervisor call old and new word locations
  localparam logic [ADDR_W-1:0] SVC_OLD = 12'd32;
  localparam logic [ADDR_W-1:0] SVC_NEW = 12'd96;
  localparam int LOG_MAX_BYTES = 256;
  // ---------------------------------------------------------------
  // decimal sign and zone codes
  // ---------------------------------------------------------------
  localparam logic [3:0] EBC_PLUS = 4'hc;
  localparam logic [3:0] EBC_MINUS = 4'hd;
  localparam logic [3:0] ASC_PLUS = 4'ha;
  localparam logic [3:0] ASC_MINUS = 4'hb;
  localparam logic [3:0] EBC_ZONE = 4'hf;
  localparam logic [3:0] ASC_ZONE = 4'h5;
  // ---------------------------------------------------------------
  // interrupt classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_NONE = 3'b000,
    CLS_MCH = 3'b001,
    CLS_PGM = 3'b010,
    CLS_SVC = 3'b011,
    CLS_EXT = 3'b100,
    CLS_IO = 3'b101
  } irq_cls_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_LOG = 3'b010,
    ST_STORE = 3'b011,
    ST_FETCH = 3'b100,
    ST_HALT = 3'b101
  } cpu_st_t;
endpackage : psw_ctl_pkg

// ---- logic/log_buf.sv ----
`timescale 1ns/1ns
`default_nettype none
// small memory holding internal circuit status words for the log-out
module log_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64
) (
  // clock
  input wire logic core_clk,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 1 || WIDTH < 1) begin
      $error("log_buf: bad size");
    end
  end

  // write port and registered read
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : log_buf
`default_nettype wire

// ---- logic/psw_interrupt_mask_and_state.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// (RULE_01) status word bits 0..7 form the system mask for I/O and external
// (RULE_02) mask bit zero blocks its interrupt, one allows it
// (RULE_03) bit 0 multiplexor, 1..6 selectors, 7 external; one shared I/O
// (RULE_04) interrupting channel identity goes into the old word's code
// (RULE_05) masked I/O or external requests stay pending until unmasked
// (RULE_06) bit 13 zero ignores machine checks entirely; here only while the error-stop switch is off, else log-out and halt
// (RULE_07) error-stop switch on halts on machine check instead
// (RULE_08) machine interrupt stores old word at 48, new from 112
// (RULE_09) log-out from 128 before machine interrupt or halt, 4..256 bytes
// (RULE_10) program interrupt stores old word at 40, new from 104
// (RULE_11) bits 36..39 mask only four exceptions
// (RULE_12) other program exceptions and supervisor call never masked
// (RULE_13) bit 12 selects EBCDIC (0) or ASCII (1) decimal code
// (RULE_14) sign codes: ASCII a/b, EBCDIC plus c minus d
// (RULE_15) unpack zone bits follow the ASCII mode bit
// (RULE_16) bit 14 set stops instruction fetch until interrupt reloads word
// (RULE_17) only I/O or external wake from wait; others only while running
// (RULE_18) bit 15 one is problem state; privileged op then traps
// (RULE_19) I/O interrupt stores old word at 56, new from 120
// (RULE_20) external interrupt stores old word at 24, new from 88
// (RULE_21) mask bits 36..39 gate fxovf, dcovf, expuf, significance
module psw_interrupt_mask_and_state
  import psw_ctl_pkg::*;
#(
  parameter int LOG_BYTES = 16,
  parameter int LOG_W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // status word load (from instruction unit or storage)
  input wire logic psw_load,
  input wire logic [psw_ctl_pkg::PSW_W-1:0] psw_in,
  input wire logic sys_mask_load,
  input wire logic [7:0] sys_mask_in,
  input wire logic prog_mask_load,
  input wire logic [3:0] prog_mask_in,
  // interrupt sources
  input wire logic [psw_ctl_pkg::NUM_CHAN-1:0] chan_req,
  input wire logic ext_req,
  input wire logic mchk_req,
  input wire logic [psw_ctl_pkg::NUM_PEXC-1:0] pgm_exc,
  input wire logic svc_req,
  input wire logic [7:0] svc_code,
  input wire logic priv_op,
  input wire logic error_stop_sw,
  // log-out source
  input wire logic [LOG_W-1:0] diag_word,
  // storage side
  input wire logic [psw_ctl_pkg::PSW_W-1:0] stor_rdata,
  input wire logic stor_ack,
  output logic stor_req,
  output logic stor_we,
  output logic [psw_ctl_pkg::ADDR_W-1:0] stor_addr,
  output logic [psw_ctl_pkg::PSW_W-1:0] stor_wdata,
  // state outputs
  output logic [psw_ctl_pkg::PSW_W-1:0] program_status_word,
  output logic fetch_en,
  output logic halted,
  output logic problem_state,
  output logic chan_ack,
  output logic ext_ack,
  // decimal code outputs
  output logic [3:0] sign_plus,
  output logic [3:0] sign_minus,
  output logic [3:0] unpack_zone
);
  import psw_ctl_pkg::*;

  localparam int LOG_WORDS = LOG_BYTES / 4;
  localparam int LA_W = (LOG_WORDS > 1) ? $clog2(LOG_WORDS) : 1;

  initial begin
    if (LOG_BYTES < 4 || LOG_BYTES > LOG_MAX_BYTES || LOG_BYTES % 4 != 0)
    begin
      $error("log-out size out of range");
    end
  end

  // -----------------------------------------------------------------
  // reset release
  // -----------------------------------------------------------------
  logic rst_a_ff, rst_b_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire logic rst_n = rst_b_ff;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [2:0] chan_pick(input logic [NUM_CHAN-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[2:0];
      end
    end
    return r;
  endfunction : chan_pick

  function automatic logic [3:0] exc_code(input logic [NUM_PEXC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_PEXC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction : exc_code

  // -----------------------------------------------------------------
  // mask decode
  // -----------------------------------------------------------------
  logic [PSW_W-1:0] psw_ff;
  cpu_st_t st_ff;
  logic [NUM_CHAN-1:0] chan_pend_ff;
  logic ext_pend_ff;
  // (RULE_01) system mask field
  wire logic [7:0] sys_mask = psw_ff[SYS_MASK_HI:SYS_MASK_LO];
  // (RULE_03) bit per channel, bit 7 external
  wire logic [NUM_CHAN-1:0] chan_live = chan_pend_ff & sys_mask[6:0];
  // (RULE_02) zero blocks, one allows
  wire logic ext_live = ext_pend_ff & sys_mask[EXT_MASK_BIT];
  wire logic [3:0] pmask = psw_ff[PMASK_HI:PMASK_LO];
  logic [NUM_PEXC-1:0] exc_gate;
  always_comb begin
    exc_gate = '1;
    // (RULE_21) mask bit per maskable exception
    exc_gate[PEXC_FXOVF] = pmask[0];
    exc_gate[PEXC_DCOVF] = pmask[1];
    exc_gate[PEXC_EXPUF] = pmask[2];
    exc_gate[PEXC_SIGNF] = pmask[3];
  end
  // (RULE_18) privileged op in problem state traps
  wire logic priv_trap = priv_op & psw_ff[PROB_BIT];
  // (RULE_11) only four bits suppress; (RULE_12) rest always pass
  wire logic [NUM_PEXC-1:0] exc_live =
    (pgm_exc & exc_gate) | (NUM_PEXC'(priv_trap) << PEXC_PRIV);
  wire logic running = (st_ff == ST_RUN);

  // -----------------------------------------------------------------
  // pending requests
  // -----------------------------------------------------------------
  logic [NUM_CHAN-1:0] chan_take;
  logic ext_take;
  // (RULE_05) requests held until the mask opens; set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_pend_ff <= '0;
      ext_pend_ff <= 1'b0;
    end else if (ce) begin
      chan_pend_ff <= (chan_pend_ff & ~chan_take) | chan_req;
      ext_pend_ff <= (ext_pend_ff & ~ext_take) | ext_req;
    end
  end

  // -----------------------------------------------------------------
  // interrupt selection
  // -----------------------------------------------------------------
  irq_cls_t pick;
  logic [15:0] pick_code;
  always_comb begin
    pick = CLS_NONE;
    pick_code = 16'h0;
    chan_take = '0;
    ext_take = 1'b0;
    // (RULE_06) mask zero ignores the check; (RULE_07) switch halts
    if (running && mchk_req && (psw_ff[MCHK_MASK_BIT] || error_stop_sw))
    begin
      pick = CLS_MCH;
    end else if (running && (|exc_live)) begin
      // (RULE_17) program and call only while running
      pick = CLS_PGM;
      pick_code = {12'h0, exc_code(exc_live)};
    end else if (running && svc_req) begin
      pick = CLS_SVC;
      pick_code = {8'h0, svc_code};
    end else if (ext_live && (running || st_ff == ST_WAIT)) begin
      pick = CLS_EXT;
      ext_take = 1'b1;
    end else if ((|chan_live) && (running || st_ff == ST_WAIT)) begin
      // (RULE_04) channel identity into the code
      pick = CLS_IO;
      pick_code = {13'h0, chan_pick(chan_live)};
      chan_take[chan_pick(chan_live)] = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  irq_cls_t cls_ff;
  logic [15:0] code_ff;
  logic [LA_W-1:0] log_idx_ff;
  logic halt_after_ff;
  logic [LOG_W-1:0] log_rd;

  // snapshot of circuit status, replayed into storage
  log_buf #(.WIDTH(LOG_W), .DEPTH(LOG_WORDS)) u_log (
    .core_clk(core_clk),
    .ce(ce),
    .wr_en(running && pick == CLS_MCH),
    .wr_addr(log_idx_ff),
    .wr_data(diag_word),
    .rd_addr(log_idx_ff),
    .rd_data(log_rd)
  );

  function automatic logic [ADDR_W-1:0] old_loc(input irq_cls_t c);
    case (c)
      CLS_MCH: old_loc = MCH_OLD;
      CLS_PGM: old_loc = PGM_OLD;
      CLS_EXT: old_loc = EXT_OLD;
      CLS_IO: old_loc = IO_OLD;
      default: old_loc = SVC_OLD;
    endcase
  endfunction : old_loc

  function automatic logic [ADDR_W-1:0] new_loc(input irq_cls_t c);
    case (c)
      CLS_MCH: new_loc = MCH_NEW;
      CLS_PGM: new_loc = PGM_NEW;
      CLS_EXT: new_loc = EXT_NEW;
      CLS_IO: new_loc = IO_NEW;
      default: new_loc = SVC_NEW;
    endcase
  endfunction : new_loc

  // state and storage traffic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RUN;
      cls_ff <= CLS_NONE;
      code_ff <= 16'h0;
      log_idx_ff <= '0;
      halt_after_ff <= 1'b0;
      stor_req <= 1'b0;
      stor_we <= 1'b0;
      stor_addr <= '0;
      stor_wdata <= '0;
    end else if (ce) begin
      case (st_ff)
        ST_RUN, ST_WAIT: begin
          stor_req <= 1'b0;
          if (pick == CLS_MCH) begin
            // (RULE_09) log out first, then interrupt or halt
            cls_ff <= pick;
            halt_after_ff <= error_stop_sw;
            log_idx_ff <= '0;
            st_ff <= ST_LOG;
          end else if (pick != CLS_NONE) begin
            cls_ff <= pick;
            code_ff <= pick_code;
            st_ff <= ST_STORE;
          end else if (psw_ff[WAIT_BIT]) begin
            // (RULE_16) wait bit stops fetching
            st_ff <= ST_WAIT;
          end else begin
            st_ff <= ST_RUN;
          end
        end
        ST_LOG: begin
          stor_req <= 1'b1;
          stor_we <= 1'b1;
          // (RULE_09) log area from location 128
          stor_addr <= LOG_BASE + ADDR_W'({log_idx_ff, 2'b00});
          stor_wdata <= PSW_W'(log_rd);
          if (stor_req && stor_ack) begin
            stor_req <= 1'b0;
            if (log_idx_ff == LA_W'(LOG_WORDS - 1)) begin
              st_ff <= halt_after_ff ? ST_HALT : ST_STORE;
            end else begin
              log_idx_ff <= log_idx_ff + 1'b1;
            end
          end
        end
        ST_STORE: begin
          // (RULE_08) (RULE_10) (RULE_19) (RULE_20) old word location
          stor_req <= 1'b1;
          stor_we <= 1'b1;
          stor_addr <= old_loc(cls_ff);
          stor_wdata <= psw_ff;
          stor_wdata[ICODE_HI:ICODE_LO] <= code_ff;
          if (stor_req && stor_ack) begin
            stor_req <= 1'b0;
            st_ff <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // new word fetched from class location
          stor_req <= 1'b1;
          stor_we <= 1'b0;
          stor_addr <= new_loc(cls_ff);
          if (stor_req && stor_ack) begin
            stor_req <= 1'b0;
            st_ff <= ST_RUN;
          end
        end
        ST_HALT: begin
          // (RULE_07) error stop holds until reset
          stor_req <= 1'b0;
        end
        default: begin
          st_ff <= ST_RUN;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // status word register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psw_ff <= '0;
    end else if (ce) begin
      if (st_ff == ST_FETCH && stor_req && stor_ack) begin
        psw_ff <= stor_rdata;
      end else if (running && psw_load) begin
        psw_ff <= psw_in;
      end else if (running) begin
        if (sys_mask_load) begin
          psw_ff[SYS_MASK_HI:SYS_MASK_LO] <= sys_mask_in;
        end
        if (prog_mask_load) begin
          psw_ff[PMASK_HI:PMASK_LO] <= prog_mask_in;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_status_word <= '0;
      fetch_en <= 1'b0;
      halted <= 1'b0;
      problem_state <= 1'b0;
      chan_ack <= 1'b0;
      ext_ack <= 1'b0;
      sign_plus <= EBC_PLUS;
      sign_minus <= EBC_MINUS;
      unpack_zone <= EBC_ZONE;
    end else if (ce) begin
      program_status_word <= psw_ff;
      // (RULE_16) no fetch unless running with wait bit clear
      fetch_en <= running && !psw_ff[WAIT_BIT] && pick == CLS_NONE;
      halted <= (st_ff == ST_HALT);
      // (RULE_18) bit 15 one is problem state
      problem_state <= psw_ff[PROB_BIT];
      chan_ack <= |chan_take;
      ext_ack <= ext_take;
      // (RULE_13) (RULE_14) sign codes by mode
      sign_plus <= psw_ff[ASCII_BIT] ? ASC_PLUS : EBC_PLUS;
      sign_minus <= psw_ff[ASCII_BIT] ? ASC_MINUS : EBC_MINUS;
      // (RULE_15) unpack zone by mode
      unpack_zone <= psw_ff[ASCII_BIT] ? ASC_ZONE : EBC_ZONE;
    end
  end
endmodule : psw_interrupt_mask_and_state
`default_nettype wire

// ---- verif/psw_ctl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module psw_ctl_props
#(
  parameter int LOG_BYTES = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // panel and storage
  input wire logic error_stop_sw,
  input wire logic stor_ack,
  input wire logic stor_req,
  input wire logic stor_we,
  input wire logic [psw_ctl_pkg::ADDR_W-1:0] stor_addr,
  // state outputs
  input wire logic [psw_ctl_pkg::PSW_W-1:0] program_status_word,
  input wire logic fetch_en,
  input wire logic halted,
  input wire logic problem_state,
  input wire logic chan_ack,
  input wire logic ext_ack,
  input wire logic [3:0] sign_plus,
  input wire logic [3:0] sign_minus,
  input wire logic [3:0] unpack_zone
);
  import psw_ctl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [ADDR_W-1:0] last_log;
  logic [15:0] pw;
  logic wr;
  // short names for the watched fields
  assign last_log = LOG_BASE + ADDR_W'(LOG_BYTES - 4);
  assign pw = program_status_word[15:0];
  assign wr = stor_req && stor_we;
  chk_ext_gate:
    assert property (ext_ack |-> pw[EXT_MASK_BIT])
    else $error("external taken while masked");
  chk_chan_gate:
    assert property (chan_ack |-> |pw[6:0])
    else $error("channel taken with all masked");
  chk_io_old:
    assert property ($rose(chan_ack) |=> wr && stor_addr == IO_OLD)
    else $error("io old word misplaced");
  chk_ext_old:
    assert property ($rose(ext_ack) |=> wr && stor_addr == EXT_OLD)
    else $error("external old word misplaced");
  chk_mch_new:
    assert property (wr && stor_ack && stor_addr == MCH_OLD |=> ##[0:2]
      stor_req && !stor_we && stor_addr == MCH_NEW)
    else $error("machine new word not fetched");
  chk_pgm_new:
    assert property (wr && stor_ack && stor_addr == PGM_OLD |=> ##[0:2]
      stor_req && !stor_we && stor_addr == PGM_NEW)
    else $error("program new word not fetched");
  chk_log_gate:
    assert property (stor_req && stor_addr == LOG_BASE |->
      pw[MCHK_MASK_BIT] || error_stop_sw)
    else $error("log-out while checks ignored");
  chk_log_first:
    assert property (wr && stor_ack && stor_addr == last_log && !error_stop_sw
      |=> ##[0:2] wr && stor_addr == MCH_OLD)
    else $error("old word not after log-out");
  chk_halt_cause:
    assert property ($rose(halted) |-> error_stop_sw)
    else $error("halt without error stop");
  chk_ascii_code:
    assert property (pw[ASCII_BIT] && $past(pw[ASCII_BIT]) |->
      {sign_plus, sign_minus, unpack_zone} == {ASC_PLUS, ASC_MINUS, ASC_ZONE})
    else $error("ascii codes wrong");
  chk_ebc_code:
    assert property (!pw[ASCII_BIT] && !$past(pw[ASCII_BIT]) |->
      {sign_plus, sign_minus, unpack_zone} == {EBC_PLUS, EBC_MINUS, EBC_ZONE})
    else $error("ebcdic codes wrong");
  chk_wait_stop:
    assert property (pw[WAIT_BIT] && $past(pw[WAIT_BIT]) |-> !fetch_en)
    else $error("fetch while waiting");
  chk_wait_wake:
    assert property (pw[WAIT_BIT] && $rose(stor_req) && stor_we |->
      $past(chan_ack) || $past(ext_ack))
    else $error("wrong class left wait");
  chk_prob_bit:
    assert property ($stable(pw[PROB_BIT]) |-> problem_state == pw[PROB_BIT])
    else $error("problem state flag wrong");
  // main scenarios
  cover property ($rose(chan_ack));
  cover property ($rose(ext_ack));
  cover property ($rose(halted));
  cover property (wr && stor_addr == LOG_BASE);
endmodule : psw_ctl_props
bind psw_interrupt_mask_and_state psw_ctl_props #(
  .LOG_BYTES(LOG_BYTES)
) u_props (
  .core_clk, .nrst, .error_stop_sw, .stor_ack, .stor_req, .stor_we,
  .stor_addr, .program_status_word, .fetch_en, .halted, .problem_state,
  .chan_ack, .ext_ack, .sign_plus, .sign_minus, .unpack_zone
);
`default_nettype wire

// ---- verif/stor_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// storage model: answers each access once, promptly or after a stall
module stor_model (
  // clock and pace
  input wire logic core_clk,
  input wire logic slow,
  // storage port
  input wire logic stor_req,
  input wire logic stor_we,
  input wire logic [psw_ctl_pkg::ADDR_W-1:0] stor_addr,
  output logic stor_ack,
  output logic [psw_ctl_pkg::PSW_W-1:0] stor_rdata
);
  import psw_ctl_pkg::*;
  logic [1:0] stall_ff;
  initial begin
    stall_ff = 2'h0;
    stor_ack = 1'b0;
    stor_rdata = '0;
  end
  // data toggles outside the answer cycle so stale reads show
  always @(posedge core_clk) begin
    stor_ack <= 1'b0;
    stor_rdata <= ~stor_rdata;
    if (stor_req && !stor_ack && slow && stall_ff != 2'h2) begin
      stall_ff <= stall_ff + 2'h1;
    end else if (stor_req && !stor_ack) begin
      stall_ff <= 2'h0;
      stor_ack <= 1'b1;
      // fresh word: running, supervisor, all masked, checks enabled
      if (!stor_we) begin
        stor_rdata <= {stor_addr, 36'h0, 16'h2000};
      end
    end
  end
endmodule : stor_model
`default_nettype wire

// ---- verif/tb_psw_interrupt_mask_and_state.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_psw_interrupt_mask_and_state;
  import psw_ctl_pkg::*;
  localparam int LOGB = 8;
  logic core_clk, nrst, ce, slow, psw_load, sys_mask_load, prog_mask_load;
  logic ext_req, mchk_req, svc_req, priv_op, error_stop_sw, stor_ack;
  logic stor_req, stor_we, fetch_en, halted, problem_state, chan_ack, ext_ack;
  logic [63:0] psw_in, stor_rdata, stor_wdata, program_status_word;
  logic [7:0] sys_mask_in, svc_code;
  logic [3:0] prog_mask_in, sign_plus, sign_minus, unpack_zone, m;
  logic [6:0] chan_req;
  logic [14:0] pgm_exc;
  logic [11:0] stor_addr;
  logic [31:0] diag_word, rng;
  logic [29:0] exp_q[$];
  int err_total, num_checks, ch;
  psw_interrupt_mask_and_state #(.LOG_BYTES(LOGB)) u_dut (
    .core_clk, .nrst, .ce, .psw_load, .psw_in, .sys_mask_load,
    .sys_mask_in, .prog_mask_load, .prog_mask_in, .chan_req, .ext_req,
    .mchk_req, .pgm_exc, .svc_req, .svc_code, .priv_op, .error_stop_sw,
    .diag_word, .stor_rdata, .stor_ack, .stor_req, .stor_we, .stor_addr,
    .stor_wdata, .program_status_word, .fetch_en, .halted, .problem_state,
    .chan_ack, .ext_ack, .sign_plus, .sign_minus, .unpack_zone
  );
  stor_model u_stor (
    .core_clk, .slow, .stor_req, .stor_we, .stor_addr, .stor_ack, .stor_rdata
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_acc(input logic [29:0] e);
    chk(64'({stor_we, stor_addr}), 64'(e[28:16]));
    if (e[29]) chk(64'(stor_wdata[31:16]), 64'(e[15:0]));
  endtask : chk_acc
  // two edges: one-shot inputs dropped on the first
  task automatic step;
    @(posedge core_clk);
    {psw_load, sys_mask_load, prog_mask_load, ext_req, mchk_req} <= '0;
    {svc_req, priv_op, chan_req, pgm_exc} <= '0;
    diag_word <= rng;
    slow <= rng[0];
    rng = xs(rng);
    @(posedge core_clk);
  endtask : step
  task automatic ld(input logic [63:0] w);
    psw_in <= w;
    psw_load <= 1'b1;
    repeat (2) step;
  endtask : ld
  task automatic note_int(input logic [11:0] o, input logic [11:0] n,
                          input logic c, input logic [15:0] code);
    exp_q.push_back({c, 1'b1, o, code});
    exp_q.push_back({2'b00, n, 16'h0});
  endtask : note_int
  task automatic note_log;
    for (int k = 0; k < LOGB / 4; k++) begin
      exp_q.push_back({2'b01, LOG_BASE + 12'(4 * k), 16'h0});
    end
  endtask : note_log
  // wait for notes to be used up, then watch for stray accesses
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      step;
      n++;
    end
    if (n == 300) begin
      err_total++;
      complete_run;
    end
    repeat (6) step;
  endtask : drain
  // monitor: each accepted access takes the oldest note
  always @(posedge core_clk) begin
    if (nrst && stor_req && stor_ack) begin
      if (exp_q.size() == 0) chk(64'(stor_addr), 64'hfff);
      else chk_acc(exp_q.pop_front());
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    rng = 32'd18304;
    err_total = 0;
    num_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    {psw_load, sys_mask_load, prog_mask_load, ext_req, mchk_req} = '0;
    {svc_req, priv_op, error_stop_sw, slow, chan_req, pgm_exc} = '0;
    {psw_in, sys_mask_in, prog_mask_in, svc_code, diag_word} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) step;
    chk(64'({sign_plus, sign_minus, unpack_zone}), 64'hcdf);
    ld(64'h3000);
    chk(64'({sign_plus, sign_minus, unpack_zone}), 64'hab5);
    ch = int'(rng % 7);
    chan_req <= 7'h7f;
    repeat (4) step;
    note_int(IO_OLD, IO_NEW, 1'b1, 16'(ch));
    sys_mask_in <= 8'h01 << ch;
    sys_mask_load <= 1'b1;
    drain;
    chk(program_status_word, {IO_NEW, 36'h0, 16'h2000});
    note_int(IO_OLD, IO_NEW, 1'b1, (ch == 0) ? 16'h1 : 16'h0);
    sys_mask_in <= 8'h7f;
    sys_mask_load <= 1'b1;
    drain;
    ext_req <= 1'b1;
    step;
    note_int(EXT_OLD, EXT_NEW, 1'b0, 16'h0);
    sys_mask_in <= 8'h80;
    sys_mask_load <= 1'b1;
    drain;
    for (int i = 0; i < 15; i++) begin
      m = (i == 8) ? 4'h1 : (i == 10) ? 4'h2 : 4'h0;
      m = (i == 13) ? 4'h4 : (i == 14) ? 4'h8 : m;
      pgm_exc[i] <= 1'b1;
      if (m == 4'h0) note_int(PGM_OLD, PGM_NEW, 1'b1, 16'(i + 1));
      drain;
      if (m != 4'h0) begin
        prog_mask_in <= m;
        prog_mask_load <= 1'b1;
        step;
        pgm_exc[i] <= 1'b1;
        note_int(PGM_OLD, PGM_NEW, 1'b1, 16'(i + 1));
        drain;
      end
    end
    svc_code <= rng[7:0];
    svc_req <= 1'b1;
    note_int(SVC_OLD, SVC_NEW, 1'b1, {8'h00, rng[7:0]});
    drain;
    priv_op <= 1'b1;
    drain;
    ld(64'ha000);
    chk(64'(problem_state), 64'h1);
    priv_op <= 1'b1;
    note_int(PGM_OLD, PGM_NEW, 1'b1, 16'h3);
    drain;
    chk(64'(problem_state), 64'h0);
    ld(64'h0);
    mchk_req <= 1'b1;
    drain;
    ld(64'h2000);
    note_log;
    note_int(MCH_OLD, MCH_NEW, 1'b0, 16'h0);
    mchk_req <= 1'b1;
    drain;
    ld(64'h6080);
    chk(64'(fetch_en), 64'h0);
    {mchk_req, svc_req, priv_op} <= 3'h7;
    pgm_exc <= 15'h0001;
    drain;
    ext_req <= 1'b1;
    note_int(EXT_OLD, EXT_NEW, 1'b0, 16'h0);
    drain;
    chk(64'(fetch_en), 64'h1);
    // clock enable low: a word load must not land
    ce <= 1'b0;
    ld(64'h1000);
    chk(64'({sign_plus, sign_minus, unpack_zone}), 64'hcdf);
    ce <= 1'b1;
    error_stop_sw <= 1'b1;
    ld(64'h0);
    note_log;
    mchk_req <= 1'b1;
    drain;
    chk(64'(halted), 64'h1);
    complete_run;
  end
endmodule : tb_psw_interrupt_mask_and_state
`default_nettype wire
